// ---- core/plc_cfg.svh ----
// timing counts, code limits and auto-timer constants for the pulse-count led level link
`ifndef PLC_CFG_SVH
`define PLC_CFG_SVH
`define PLC_CLK_HZ 10000000
`define PLC_OSC_HZ 1000000
`define PLC_OSC_DIV (`PLC_CLK_HZ / `PLC_OSC_HZ)
`define PLC_LATCH_TIMEOUT_US 500
`define PLC_OFF_TIMEOUT_US 500
`define PLC_LATCH_TICKS (`PLC_LATCH_TIMEOUT_US * `PLC_OSC_HZ / 1000000)
`define PLC_OFF_TICKS (`PLC_OFF_TIMEOUT_US * `PLC_OSC_HZ / 1000000)
`define PLC_HIGH_MAX_US 75
`define PLC_HIGH_CYCLES (`PLC_HIGH_MAX_US * (`PLC_CLK_HZ / 1000000))
`define PLC_LOW_CYCLES 10
`define PLC_CODE_MAX 16
`define PLC_TIMER_CODE_LAST 4
`define PLC_TIMER_US_PER_NF 10000
`define PLC_CAP_NF 100
`endif

// ---- core/plc_device.sv ----
// device end: edge counter, latch and off timeouts, level table and flash auto-timer
// Operation
// - count rising edges into 16 level codes
// - one edge selects maximum current
// - high 500us latches code, clears count
// - host sends fresh burst per change
// - code maps to fixed logarithmic current fraction, code 16 to zero
// - low over 500us enters shutdown
// - shutdown clears data and address registers
// - auto-timer runs only for codes 1-4
// - high to low group ignores timer
// - low to high group restarts timer
// - new level resets converter stage
// - expired auto-timer disables output
// - grounded timer pin disables auto-timer
// - host never drives timer pin high
// - select input: flash or torch
// - host drives select open-drain only
// - timing from internal 1MHz oscillator
// - host high phase at most 75us
`timescale 1ns/10ps
`include "plc_cfg.svh"
module plc_device #(
	parameter int TIMER_TICKS = `PLC_TIMER_US_PER_NF * `PLC_CAP_NF
) (
	input wire logic CLK_IN, // 10 MHz clock
	input wire logic SYS_RST_IN, // synchronous reset, active high
	plc_link_if.dev LINK, // control wire side
	output logic [9:0] LEVEL_PERMILLE_OUT, // output current, tenths of percent
	output logic [4:0] CODE_OUT, // latched code, 0 when off
	output logic OUTPUT_ON_OUT, // output current enabled
	output logic TORCH_OUT, // torch selected
	output logic CONV_RESET_OUT, // one-cycle converter stage reset
	output logic TIMER_RUN_OUT // auto-timer running
);
	// elaboration checks; the prescaler and timeout counter widths bound the timing
	if (TIMER_TICKS < 1) begin : g_bad_timer
		$error("TIMER_TICKS must be at least one");
	end
	if (`PLC_OSC_DIV < 1 || `PLC_OSC_DIV > 16) begin : g_bad_div
		$error("oscillator divider does not fit the four-bit prescaler");
	end
	if (`PLC_LATCH_TICKS < 1 || `PLC_LATCH_TICKS > 1023) begin : g_bad_latch
		$error("latch timeout does not fit the ten-bit timeout counter");
	end
	if (`PLC_OFF_TICKS < 1 || `PLC_OFF_TICKS > 1023) begin : g_bad_off
		$error("off timeout does not fit the ten-bit timeout counter");
	end

	// state, edge count (the address register) and latched code (the data register)
	plc_pkg::plc_dev_state_t state_reg, state_next;
	plc_pkg::plc_code_t count_reg, count_next;
	plc_pkg::plc_code_t data_reg, data_next;
	logic [3:0] div_reg;
	logic [9:0] tmo_reg;
	logic [31:0] timer_reg;
	logic timer_active_reg;
	logic expired_reg;
	logic en_d_reg;
	logic [9:0] level_tab [0:15];

	// percentage table in tenths, code 1 first
	assign level_tab = '{10'd1000, 10'd891, 10'd794, 10'd708, 10'd631, 10'd562, 10'd501,
		10'd447, 10'd398, 10'd355, 10'd316, 10'd282, 10'd251, 10'd224, 10'd200, 10'd0};

	// oscillator tick and line events
	wire osc_tick = (div_reg == 4'(`PLC_OSC_DIV - 1));
	wire rise = LINK.en_set & ~en_d_reg;
	wire fall = ~LINK.en_set & en_d_reg;
	wire tmo_hit = osc_tick & (tmo_reg == 10'(`PLC_LATCH_TICKS - 1));
	wire off_hit = osc_tick & (tmo_reg == 10'(`PLC_OFF_TICKS - 1));
	wire latch_now = (state_reg != plc_pkg::PLC_OFF) & LINK.en_set & tmo_hit
		& (count_reg != 5'h00);
	wire shut_now = (state_reg != plc_pkg::PLC_OFF) & ~LINK.en_set & off_hit;
	wire new_high = (count_reg != 5'h00) && (count_reg <= 5'(`PLC_TIMER_CODE_LAST));
	wire old_high = (data_reg != 5'h00) && (data_reg <= 5'(`PLC_TIMER_CODE_LAST));
	wire timer_allowed = ~LINK.timer_cap_pin_low;
	wire out_on = (state_reg == plc_pkg::PLC_ON) & ~expired_reg & LINK.en_set;

	// selection for the registered outputs; code 0 never occurs in the on state
	wire [9:0] level_sel = out_on ? level_tab[4'(data_reg - 5'h01)] : 10'h000;
	wire torch_sel = out_on & LINK.flash_torch_select;
	wire timer_run = timer_active_reg & timer_allowed & ~expired_reg & out_on;

	// auto-timer decode; a grounded timer pin pauses the count rather than clearing it
	wire timer_restart = new_high & ~old_high;
	wire timer_step = timer_active_reg & timer_allowed & ~expired_reg & osc_tick;
	wire timer_done = (timer_reg == 32'(TIMER_TICKS - 1));

	// state and registers
	always_comb begin
		state_next = state_reg;
		count_next = count_reg;
		data_next = data_reg;
		case (state_reg)
			plc_pkg::PLC_OFF: begin
				if (rise) begin
					state_next = plc_pkg::PLC_COUNT;
					count_next = 5'h01;
				end
			end
			plc_pkg::PLC_COUNT, plc_pkg::PLC_ON: begin
				if (rise && count_reg != 5'(`PLC_CODE_MAX)) begin
					count_next = count_reg + 5'h01;
				end
				if (latch_now) begin
					data_next = count_reg;
					count_next = 5'h00;
					state_next = plc_pkg::PLC_ON;
				end
				if (shut_now) begin
					state_next = plc_pkg::PLC_OFF;
					count_next = 5'h00;
					data_next = 5'h00;
				end
			end
			default: begin
				state_next = plc_pkg::PLC_OFF;
			end
		endcase
	end

	// oscillator prescaler: one enable pulse per internal oscillator period
	always_ff @(posedge CLK_IN) begin
		if (SYS_RST_IN) begin
			div_reg <= 4'h0;
		end else begin
			div_reg <= osc_tick ? 4'h0 : div_reg + 4'h1;
		end
	end

	// line history for edge detection; reset value matches the idle low line
	always_ff @(posedge CLK_IN) begin
		if (SYS_RST_IN) begin
			en_d_reg <= 1'b0;
		end else begin
			en_d_reg <= LINK.en_set;
		end
	end

	// timeout counter restarts on every line edge and saturates, so one long
	// level can latch or shut down only once
	always_ff @(posedge CLK_IN) begin
		if (SYS_RST_IN) begin
			tmo_reg <= 10'h000;
		end else if (rise | fall) begin
			tmo_reg <= 10'h000;
		end else if (osc_tick && tmo_reg != 10'h3ff) begin
			tmo_reg <= tmo_reg + 10'h001;
		end
	end

	always_ff @(posedge CLK_IN) begin
		if (SYS_RST_IN) begin
			state_reg <= plc_pkg::PLC_OFF;
			count_reg <= 5'h00;
			data_reg <= 5'h00;
		end else begin
			state_reg <= state_next;
			count_reg <= count_next;
			data_reg <= data_next;
		end
	end

	// flash auto-timer; counts on the oscillator tick
	always_ff @(posedge CLK_IN) begin
		if (SYS_RST_IN || shut_now) begin
			timer_reg <= 32'h0;
			timer_active_reg <= 1'b0;
			expired_reg <= 1'b0;
		end else if (latch_now) begin
			if (timer_restart) begin
				timer_reg <= 32'h0;
				expired_reg <= 1'b0;
			end
			timer_active_reg <= new_high;
			if (!new_high) begin
				expired_reg <= 1'b0;
			end
		end else if (timer_step) begin
			if (timer_done) begin
				expired_reg <= 1'b1;
			end else begin
				timer_reg <= timer_reg + 32'h1;
			end
		end
	end

	// registered outputs
	always_ff @(posedge CLK_IN) begin
		if (SYS_RST_IN) begin
			LEVEL_PERMILLE_OUT <= 10'h000;
			CODE_OUT <= 5'h00;
			OUTPUT_ON_OUT <= 1'b0;
			TORCH_OUT <= 1'b0;
			CONV_RESET_OUT <= 1'b0;
			TIMER_RUN_OUT <= 1'b0;
		end else begin
			CODE_OUT <= data_reg;
			OUTPUT_ON_OUT <= out_on;
			LEVEL_PERMILLE_OUT <= level_sel;
			TORCH_OUT <= torch_sel;
			CONV_RESET_OUT <= latch_now;
			TIMER_RUN_OUT <= timer_run;
		end
	end
endmodule

// ---- core/plc_host.sv ----
// host end: pulse burst generator for the level code and pin drivers
`timescale 1ns/10ps
`include "plc_cfg.svh"
module plc_host #(
	parameter int HOLD_CYCLES = `PLC_HIGH_CYCLES
) (
	input wire logic CLK_IN, // 10 MHz clock
	input wire logic SYS_RST_IN, // synchronous reset, active high
	plc_link_if.host LINK, // control wire side
	input wire logic SEND_IN, // one-cycle request to send a code
	input wire logic [4:0] CODE_IN, // code 1 to 16
	input wire logic SHUTDOWN_IN, // level: hold the line low while no burst runs
	input wire logic TORCH_MODE_IN, // pull timer pin low for torch
	input wire logic SELECT_TORCH_IN, // release select pin for torch
	output logic BUSY_OUT // burst in progress
);
	// elaboration check; the high time must stay under the latch threshold
	if (HOLD_CYCLES < 2 || HOLD_CYCLES > `PLC_HIGH_CYCLES) begin : g_bad_hold
		$error("HOLD_CYCLES out of range");
	end

	plc_pkg::plc_host_state_t state_reg, state_next;
	logic [9:0] cyc_reg;
	plc_pkg::plc_code_t left_reg;
	logic en_reg;

	wire code_ok = (CODE_IN != 5'h00) && (CODE_IN <= 5'(`PLC_CODE_MAX));
	wire low_done = (cyc_reg == 10'(`PLC_LOW_CYCLES - 1));
	wire high_done = (cyc_reg == 10'(HOLD_CYCLES - 1));

	// burst sequencer: low, high pairs per edge, then holds high to latch
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			plc_pkg::PLC_H_IDLE: state_next = (SEND_IN && code_ok) ? plc_pkg::PLC_H_LOW : state_reg;
			plc_pkg::PLC_H_LOW: state_next = low_done ? plc_pkg::PLC_H_HIGH : state_reg;
			plc_pkg::PLC_H_HIGH: begin
				if (high_done) begin
					state_next = (left_reg == 5'h01) ? plc_pkg::PLC_H_HOLD : plc_pkg::PLC_H_LOW;
				end
			end
			plc_pkg::PLC_H_HOLD: state_next = plc_pkg::PLC_H_IDLE;
			default: state_next = plc_pkg::PLC_H_IDLE;
		endcase
	end

	always_ff @(posedge CLK_IN) begin
		if (SYS_RST_IN) begin
			state_reg <= plc_pkg::PLC_H_IDLE;
			cyc_reg <= 10'h000;
			left_reg <= 5'h00;
			en_reg <= 1'b0;
			BUSY_OUT <= 1'b0;
		end else begin
			state_reg <= state_next;
			BUSY_OUT <= (state_next != plc_pkg::PLC_H_IDLE);
			cyc_reg <= (state_next != state_reg) ? 10'h000 : cyc_reg + 10'h001;
			if (state_reg == plc_pkg::PLC_H_IDLE && state_next == plc_pkg::PLC_H_LOW) begin
				left_reg <= CODE_IN;
			end else if (state_reg == plc_pkg::PLC_H_HIGH && high_done) begin
				left_reg <= left_reg - 5'h01;
			end
			if (state_next == plc_pkg::PLC_H_LOW) begin
				en_reg <= 1'b0;
			end else if (state_next == plc_pkg::PLC_H_HIGH) begin
				en_reg <= 1'b1;
			end else if (SHUTDOWN_IN && state_next == plc_pkg::PLC_H_IDLE) begin
				en_reg <= 1'b0;
			end
		end
	end

	// pins: timer pin only ever pulled low, select pin open-drain
	assign LINK.en_set = en_reg;
	assign LINK.timer_cap_pin_oe = TORCH_MODE_IN;
	assign LINK.flash_torch_select_oe = ~SELECT_TORCH_IN;
endmodule

// ---- core/plc_link_if.sv ----
// single control wire plus timer pin and select pin between host and device
`timescale 1ns/10ps
interface plc_link_if;
	logic en_set;
	logic timer_cap_pin_oe;
	logic flash_torch_select_oe;
	wire timer_cap_pin_low = timer_cap_pin_oe;
	wire flash_torch_select = ~flash_torch_select_oe;
	modport host (
		output en_set,
		output timer_cap_pin_oe,
		output flash_torch_select_oe
	);
	modport dev (
		input en_set,
		input timer_cap_pin_low,
		input flash_torch_select
	);
endinterface

// ---- core/plc_pkg.sv ----
// types shared by both ends of the pulse-count led level link
package plc_pkg;
	typedef enum logic [1:0] {
		PLC_OFF,
		PLC_COUNT,
		PLC_ON
	} plc_dev_state_t;
	typedef enum logic [1:0] {
		PLC_H_IDLE,
		PLC_H_LOW,
		PLC_H_HIGH,
		PLC_H_HOLD
	} plc_host_state_t;
	typedef logic [4:0] plc_code_t;
endpackage

// ---- tb/plc_assertions.sv ----
// concurrent checks on the link wire and device outputs
`timescale 1ns/10ps
module plc_assertions (
	input wire logic CLK_IN, // clock
	input wire logic SYS_RST_IN, // reset
	input wire logic en_set, // control line
	input wire logic flash_torch_select_oe, // select pull-down
	input wire logic [9:0] LEVEL_PERMILLE_OUT, // level
	input wire logic [4:0] CODE_OUT, // code
	input wire logic OUTPUT_ON_OUT, // on
	input wire logic TORCH_OUT, // torch
	input wire logic CONV_RESET_OUT, // converter reset
	input wire logic TIMER_RUN_OUT // timer running
);
	logic [12:0] low_reg;
	logic [12:0] low_next;
	default clocking cb @(posedge CLK_IN); endclocking
	default disable iff (SYS_RST_IN);
	// saturating low-time count, so a long shutdown never wraps
	assign low_next = en_set ? 13'h0 : low_reg + {12'h0, low_reg != 13'h1fff};
	always_ff @(posedge CLK_IN) begin
		low_reg <= SYS_RST_IN ? 13'h0 : low_next;
	end
	property p_max;
		CODE_OUT == 5'h1 && OUTPUT_ON_OUT |-> LEVEL_PERMILLE_OUT == 10'h3e8;
	endproperty
	a_max: assert property (p_max) else $error("code 1 level");
	property p_zero;
		CODE_OUT == 5'h10 |-> LEVEL_PERMILLE_OUT == 10'h0;
	endproperty
	a_zero: assert property (p_zero) else $error("code 16 level");
	property p_range;
		CODE_OUT <= 5'h10;
	endproperty
	a_range: assert property (p_range) else $error("code range");
	property p_tgrp;
		TIMER_RUN_OUT && $stable(CODE_OUT) |-> CODE_OUT inside {[5'h1:5'h4]};
	endproperty
	a_tgrp: assert property (p_tgrp) else $error("timer group");
	property p_conv;
		$rose(CONV_RESET_OUT) |=> !CONV_RESET_OUT ##[0:2] CODE_OUT != 5'h0;
	endproperty
	a_conv: assert property (p_conv) else $error("converter reset");
	property p_low;
		!en_set [*3] |-> !OUTPUT_ON_OUT;
	endproperty
	a_low: assert property (p_low) else $error("on while low");
	property p_torch;
		TORCH_OUT |-> OUTPUT_ON_OUT && !$past(flash_torch_select_oe);
	endproperty
	a_torch: assert property (p_torch) else $error("torch select");
	property p_off;
		low_reg == 13'h1450 |-> CODE_OUT == 5'h0 && !OUTPUT_ON_OUT;
	endproperty
	a_off: assert property (p_off) else $error("shutdown");
endmodule

// ---- tb/tb_pulse_count_led_level_control.sv ----
// bench joining host and device ends over the link
`timescale 1ns/10ps
module tb_pulse_count_led_level_control;
	logic clk = 1'b0, rst = 1'b1, send = 1'b0, shut = 1'b0, tm = 1'b0, sel = 1'b0;
	logic busy, on, torch, conv, trun;
	logic [4:0] code = 5'h0, cq;
	logic [9:0] lvl;
	logic [7:0] seed = 8'h3a;
	logic [17:0] eq[$];
	logic [17:0] e;
	int n_errors = 0, tests_run = 0, cyc = 0, n;
	logic [9:0] tbl [1:16] = '{10'h3e8, 10'h37b, 10'h31a, 10'h2c4, 10'h277, 10'h232,
		10'h1f5, 10'h1bf, 10'h18e, 10'h163, 10'h13c, 10'h11a, 10'h0fb, 10'h0e0, 10'h0c8, 10'h0};
	logic [4:0] sq [8] = '{5'h10, 5'h0f, 5'h09, 5'h05, 5'h04, 5'h03, 5'h02, 5'h01};
	always #50 clk = ~clk;
	plc_link_if link();
	plc_host #(.HOLD_CYCLES(20)) plc_host_inst (.CLK_IN(clk), .SYS_RST_IN(rst), .LINK(link),
		.SEND_IN(send), .CODE_IN(code), .SHUTDOWN_IN(shut), .TORCH_MODE_IN(tm),
		.SELECT_TORCH_IN(sel), .BUSY_OUT(busy));
	// timer of 2500 ticks outlasts three latches, so expiry lands after code 1
	plc_device #(.TIMER_TICKS(2500)) plc_device_inst (.CLK_IN(clk), .SYS_RST_IN(rst),
		.LINK(link), .LEVEL_PERMILLE_OUT(lvl), .CODE_OUT(cq), .OUTPUT_ON_OUT(on),
		.TORCH_OUT(torch), .CONV_RESET_OUT(conv), .TIMER_RUN_OUT(trun));
	plc_assertions plc_assertions_inst (.CLK_IN(clk), .SYS_RST_IN(rst), .en_set(link.en_set),
		.flash_torch_select_oe(link.flash_torch_select_oe), .LEVEL_PERMILLE_OUT(lvl),
		.CODE_OUT(cq), .OUTPUT_ON_OUT(on), .TORCH_OUT(torch), .CONV_RESET_OUT(conv),
		.TIMER_RUN_OUT(trun));
	// eight-bit maximal-length shift register for the select pin values
	function automatic logic [7:0] lfsr_next(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	task automatic check(input string what, input logic [17:0] ex, input logic [17:0] got);
		tests_run++;
		if (got !== ex) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", what, ex, got);
		end
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// burst one code and note its result; the latch lands about 5000 cycles later
	task automatic send_code(input logic [4:0] v, input logic t);
		@(negedge clk);
		seed = lfsr_next(seed);
		sel = seed[0];
		tm = t;
		send = 1'b1;
		code = v;
		eq.push_back({sel, 1'b1, v <= 5'h4 && !t, v, tbl[v]});
		@(negedge clk);
		send = 1'b0;
		check("busy", 18'h1, {17'h0, busy});
		n = 0;
		while (eq.size() != 0 && n < 7000) begin
			@(negedge clk);
			n++;
		end
		check("latch", 18'h1, {17'h0, n > 4990 && n < 7000});
		check("idle", 18'h0, {17'h0, busy});
		$display("test code %0d done", v);
	endtask
	// a latch shows as a converter reset; compare once outputs settle
	always @(negedge clk) begin
		if (conv === 1'b1) begin
			repeat (3) @(negedge clk);
			e = eq.size() != 0 ? eq.pop_front() : 18'h3ffff;
			check("torch on timer code level", e, {torch, on, trun, cq, lvl});
		end
	end
	// ceiling well above the roughly 67000 cycles that the tests take
	always @(posedge clk) begin
		cyc++;
		if (cyc == 90000) begin
			n_errors++;
			final_report();
		end
	end
	initial begin
		repeat (3) @(posedge clk);
		@(negedge clk);
		rst = 1'b0;
		code = 5'h11;
		send = 1'b1;
		@(negedge clk);
		send = 1'b0;
		check("refused code", 18'h0, {17'h0, busy});
		$display("test refused code done");
		foreach (sq[i]) send_code(sq[i], 1'b0);
		n = 0;
		while (on !== 1'b0 && n < 15000) begin
			@(negedge clk);
			n++;
		end
		check("expiry", 16'h1, {15'h0, n > 5000 && n < 15000});
		$display("test expiry done");
		send_code(5'h5, 1'b0);
		shut = 1'b1;
		repeat (5200) @(negedge clk);
		check("shutdown", 16'h0, {on, cq, lvl});
		shut = 1'b0;
		send_code(5'h2, 1'b1);
		final_report();
	end
endmodule
